// >>> verilog/dfc_regs.sv
// Control register bank of a graphics-capture front end, with two-wire slave,
// sync selection, aligned line sync, frame sync and clamp pulse generation.
// Assumes SCL/SDA and sync inputs already synchronous to I_CLK_SYS, which
// stands in for the pixel clock; SDA is open drain, resolved outside.
//
// Summary of operation
// - Offset 0x00 reads a fixed silicon revision value.
// - Offset 0x01 holds divider bits 11 to 4.
// - Upper nibble of offset 0x02 gives divider bits 3 to 0.
// - A larger divider value makes the pixel PLL run faster.
// - Offset 0x03 bits 7:6 select VCO range, bits 5:3 pump current.
// - Phase bits 7:3 delay sampling clock in steps of period/32.
// - Clamp starts the programmed clock count after line sync trailing edge.
// - Clamp stays active for the programmed clock count.
// - Aligned line sync output stays active for programmed pixel clocks.
// - Each channel gain register sets its input range.
// - Offset bits 7:1 set each channel's dc offset.
// - Polarity override bit chooses detected or programmed input polarity.
// - Polarity bit: 0 active low, 1 active high input sync.
// - Output polarity bit: 0 high pulse, 1 low pulse.
// - Source override picks programmed line sync source, else automatic unless both syncs are detected.
// - Source bit honoured with override set or both syncs detected.
// - Frame sync output inverted when bit 2 is 0.
// - Frame source override picks bit 0, else automatic choice.
// - Bit 0 picks raw or separated frame sync, only under override.
// - Clamp timing from line sync or external clamp input.
// - Controller reads all registers and writes all but revision and status over two-wire port.
// - Status bit 7 shows line sync present.
// - Status bit 6 shows the automatic line sync source.
`timescale 1ns/1ps
`include "dfc_params.svh"

module dfc_regs #(
  parameter logic [6:0] DEV_ADDR = `DFC_DEV_ADDR,
  // Arbitrary value
  parameter logic [7:0] REVISION = 8'h5A
) (
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RST,
  input  wire logic       I_SCL,
  input  wire logic       I_SDA,
  output logic            O_SDA_OUT,
  output logic            O_SDA_OE,
  input  wire logic       I_HSYNC,
  input  wire logic       I_SOG_SYNC,
  input  wire logic       I_VSYNC_RAW,
  input  wire logic       I_VSYNC_SEP,
  input  wire logic       I_EXT_CLAMP,
  input  wire logic       I_HSYNC_DETECT,
  input  wire logic       I_SOG_DETECT,
  input  wire logic       I_HSYNC_POL_DET,
  input  wire logic       I_AUTO_LINE_SYNC_SOURCE_FLAG,
  input  wire logic       I_AUTO_FRAME_SYNC_SOURCE_FLAG,
  output logic [11:0]     O_PLL_DIV,
  output logic [1:0]      O_VCO_RANGE,
  output logic [2:0]      O_PUMP_CURRENT,
  output logic [4:0]      O_SAMPLE_PHASE,
  output logic [7:0]      O_RED_GAIN,
  output logic [7:0]      O_GREEN_GAIN,
  output logic [7:0]      O_BLUE_GAIN,
  output logic [6:0]      O_RED_OFFSET,
  output logic [6:0]      O_GREEN_OFFSET,
  output logic [6:0]      O_BLUE_OFFSET,
  output logic            O_LINE_SYNC_POL,
  output logic            O_LINE_SYNC_SOG,
  output logic            O_ALIGNED_LINE_SYNC_OUTPUT,
  output logic            O_FRAME_SYNC_OUT,
  output logic            O_CLAMP
);
  import dfc_pkg::*;

  // ========================================================================
  // Helpers
  function automatic logic [7:0] reg_mask(input logic [7:0] a);
    logic [7:0] m;
    m = `DFC_MASK_FULL;
    if (a[3:0] == `DFC_REG_DIV_LOW)
      m = `DFC_MASK_NIBBLE;
    else if (a[3:0] == `DFC_REG_VCO_PUMP || a[3:0] == `DFC_REG_PHASE)
      m = `DFC_MASK_FIVE;
    else if (a[3:0] >= `DFC_REG_RED_OFS && a[3:0] != `DFC_REG_SYNC_CTL)
      m = `DFC_MASK_SEVEN;
    return m;
  endfunction

  dfc_regs_t  st;
  dfc_regs_t  nxt;
  logic       rise_c;
  logic       fall_c;
  logic       start_c;
  logic       stop_c;
  logic       wr_ok;
  logic [7:0] stat;
  logic [7:0] rd_ptr;
  logic [7:0] ctl;
  logic [7:0] cfg;
  logic       hs_pol;
  logic       hs_sog;
  logic       hs_raw;
  logic       hs_in;
  logic       lead;
  logic       trail;
  logic       vs_sep;
  logic       vs_sel;

  // ========================================================================
  // Bus conditions
  assign rise_c  = I_SCL & ~st.scl_q;
  assign fall_c  = ~I_SCL & st.scl_q;
  assign start_c = I_SCL & st.scl_q & st.sda_q & ~I_SDA;
  assign stop_c  = I_SCL & st.scl_q & ~st.sda_q & I_SDA;
  // Revision and everything above 0x0F stay untouched by writes
  assign wr_ok   = (st.ptr != `DFC_REG_REVISION) && (st.ptr[7:4] == 4'h0);

  assign stat = {I_HSYNC_DETECT,
                 I_AUTO_LINE_SYNC_SOURCE_FLAG,
                 I_HSYNC_POL_DET,
                 1'b0,
                 I_AUTO_FRAME_SYNC_SOURCE_FLAG,
                 1'b0,
                 I_SOG_DETECT,
                 1'b0};

  always_comb begin
    if (st.ptr == `DFC_REG_REVISION)
      rd_ptr = REVISION;
    else if (st.ptr[7:4] == 4'h0)
      rd_ptr = st.regs[st.ptr[3:0]] & reg_mask(st.ptr);
    else if (st.ptr == `DFC_REG_STATUS)
      rd_ptr = stat;
    else
      rd_ptr = 8'h00;
  end

  // ========================================================================
  // Sync selection
  assign ctl    = st.regs[`DFC_REG_SYNC_CTL];
  assign cfg    = st.regs[`DFC_REG_CLAMP_CTL];
  assign hs_pol = ctl[`DFC_SC_HPOL_OVR] ? ctl[`DFC_SC_HPOL] : I_HSYNC_POL_DET;
  // Programmed source counts whenever both syncs are seen, even without override
  assign hs_sog = (ctl[`DFC_SC_HSRC_OVR] | (I_HSYNC_DETECT & I_SOG_DETECT)) ?
                  ctl[`DFC_SC_HSRC] : I_AUTO_LINE_SYNC_SOURCE_FLAG;
  assign hs_raw = hs_sog ? I_SOG_SYNC : I_HSYNC;
  assign hs_in  = hs_pol ? hs_raw : ~hs_raw;
  assign lead   = hs_in & ~st.hs_prev;
  assign trail  = ~hs_in & st.hs_prev;
  assign vs_sep = ctl[`DFC_SC_VSRC_OVR] ? ctl[`DFC_SC_VSRC] :
                  I_AUTO_FRAME_SYNC_SOURCE_FLAG;
  assign vs_sel = vs_sep ? I_VSYNC_SEP : I_VSYNC_RAW;

  // ========================================================================
  // Next state
  always_comb begin
    nxt       = st;
    nxt.scl_q = I_SCL;
    nxt.sda_q = I_SDA;

    // Two-wire slave; ack and read bits change only while SCL is low
    if (start_c) begin
      nxt.st      = ST_ADDR;
      // Parked on the ack slot, so the SCL fall right after START is not a bit
      nxt.bit_cnt = `DFC_ACK_SLOT;
      nxt.drive   = 1'b0;
    end else if (stop_c) begin
      nxt.st    = ST_IDLE;
      nxt.drive = 1'b0;
    end else if (st.st != ST_IDLE) begin
      if (rise_c) begin
        if (st.bit_cnt != `DFC_ACK_SLOT)
          nxt.shift = {st.shift[6:0], I_SDA};
        else if (st.st == ST_RD && I_SDA)
          nxt.st = ST_IDLE;
      end
      if (fall_c) begin
        if (st.bit_cnt == `DFC_ACK_SLOT) begin
          nxt.bit_cnt = 4'h0;
          nxt.drive   = 1'b0;
          if (st.st == ST_RD) begin
            nxt.tx    = rd_ptr;
            nxt.ptr   = st.ptr + 8'h01;
            nxt.drive = ~rd_ptr[7];
          end
        end else if (st.bit_cnt == `DFC_BYTE_LAST) begin
          nxt.bit_cnt = `DFC_ACK_SLOT;
          nxt.drive   = 1'b1;
          unique case (st.st)
            ST_IDLE: nxt.drive = 1'b0;
            ST_ADDR: begin
              if (st.shift[7:1] == DEV_ADDR) begin
                nxt.st = st.shift[0] ? ST_RD : ST_PTR;
              end else begin
                nxt.st    = ST_IDLE;
                nxt.drive = 1'b0;
              end
            end
            ST_PTR: begin
              nxt.ptr = st.shift;
              nxt.st  = ST_WR;
            end
            ST_WR: begin
              if (wr_ok)
                nxt.regs[st.ptr[3:0]] = st.shift & reg_mask(st.ptr);
              nxt.ptr = st.ptr + 8'h01;
            end
            ST_RD: nxt.drive = 1'b0;
          endcase
        end else begin
          nxt.bit_cnt = st.bit_cnt + 4'h1;
          if (st.st == ST_RD) begin
            nxt.tx    = {st.tx[6:0], 1'b0};
            nxt.drive = ~st.tx[6];
          end
        end
      end
    end

    // Aligned line sync pulse, restarted by each leading edge
    nxt.hs_prev = hs_in;
    if (lead)
      nxt.hs_cnt = st.regs[`DFC_REG_ALIGNED_LINE_SYNC_OUTPUT_WIDTH];
    else if (st.hs_cnt != 8'h00)
      nxt.hs_cnt = st.hs_cnt - 8'h01;
    nxt.aligned_line_sync_output = (nxt.hs_cnt != 8'h00) ^ ctl[`DFC_SC_HOUT_POL];

    // Internal clamp: wait the placement count, then hold for the length
    if (trail) begin
      nxt.cl_wait = 1'b1;
      nxt.cl_on   = 1'b0;
      nxt.cl_cnt  = st.regs[`DFC_REG_CLAMP_DLY];
    end else if (st.cl_wait) begin
      if (st.cl_cnt <= 8'h01) begin
        nxt.cl_wait = 1'b0;
        nxt.cl_on   = 1'b1;
        nxt.cl_cnt  = st.regs[`DFC_REG_CLAMP_LEN];
      end else begin
        nxt.cl_cnt = st.cl_cnt - 8'h01;
      end
    end else if (st.cl_on) begin
      if (st.cl_cnt <= 8'h01)
        nxt.cl_on = 1'b0;
      else
        nxt.cl_cnt = st.cl_cnt - 8'h01;
    end
    nxt.clamp = cfg[`DFC_CC_EXT_CLAMP] ?
                (I_EXT_CLAMP ^ cfg[`DFC_CC_CLAMP_POL]) : nxt.cl_on;

    nxt.vsout = ctl[`DFC_SC_VS_NOINV] ? vs_sel : ~vs_sel;

    if (I_RST) begin
      nxt       = '0;
      nxt.st    = ST_IDLE;
      nxt.scl_q = 1'b1;
      nxt.sda_q = 1'b1;
      nxt.regs[`DFC_REG_DIV_HIGH]    = `DFC_RST_DIV_HIGH;
      nxt.regs[`DFC_REG_DIV_LOW]     = `DFC_RST_DIV_LOW;
      nxt.regs[`DFC_REG_VCO_PUMP]    = `DFC_RST_VCO_PUMP;
      nxt.regs[`DFC_REG_PHASE]       = `DFC_RST_MID;
      nxt.regs[`DFC_REG_CLAMP_DLY]   = `DFC_RST_MID;
      nxt.regs[`DFC_REG_CLAMP_LEN]   = `DFC_RST_MID;
      nxt.regs[`DFC_REG_ALIGNED_LINE_SYNC_OUTPUT_WIDTH] = `DFC_RST_ALIGNED_LINE_SYNC_OUTPUT_WIDTH;
      nxt.regs[`DFC_REG_RED_GAIN]    = `DFC_RST_MID;
      nxt.regs[`DFC_REG_GREEN_GAIN]  = `DFC_RST_MID;
      nxt.regs[`DFC_REG_BLUE_GAIN]   = `DFC_RST_MID;
      nxt.regs[`DFC_REG_RED_OFS]     = `DFC_RST_MID;
      nxt.regs[`DFC_REG_GREEN_OFS]   = `DFC_RST_MID;
      nxt.regs[`DFC_REG_BLUE_OFS]    = `DFC_RST_MID;
      nxt.regs[`DFC_REG_SYNC_CTL]    = `DFC_RST_SYNC_CTL;
      nxt.regs[`DFC_REG_CLAMP_CTL]   = `DFC_RST_CLAMP_CTL;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    st <= nxt;
  end

  // ========================================================================
  // Outputs
  assign O_SDA_OUT  = 1'b0;
  assign O_SDA_OE   = st.drive;
  // Divider is handed to the PLL whole; a larger word means a faster clock
  assign O_PLL_DIV  = {st.regs[`DFC_REG_DIV_HIGH],
                       st.regs[`DFC_REG_DIV_LOW][7:4]};
  assign O_VCO_RANGE    = st.regs[`DFC_REG_VCO_PUMP][7:6];
  assign O_PUMP_CURRENT = st.regs[`DFC_REG_VCO_PUMP][5:3];
  assign O_SAMPLE_PHASE = st.regs[`DFC_REG_PHASE][7:3];
  assign O_RED_GAIN     = st.regs[`DFC_REG_RED_GAIN];
  assign O_GREEN_GAIN   = st.regs[`DFC_REG_GREEN_GAIN];
  assign O_BLUE_GAIN    = st.regs[`DFC_REG_BLUE_GAIN];
  assign O_RED_OFFSET   = st.regs[`DFC_REG_RED_OFS][7:1];
  assign O_GREEN_OFFSET = st.regs[`DFC_REG_GREEN_OFS][7:1];
  assign O_BLUE_OFFSET  = st.regs[`DFC_REG_BLUE_OFS][7:1];
  assign O_LINE_SYNC_POL = hs_pol;
  assign O_LINE_SYNC_SOG = hs_sog;
  assign O_ALIGNED_LINE_SYNC_OUTPUT = st.aligned_line_sync_output;
  assign O_FRAME_SYNC_OUT = st.vsout;
  assign O_CLAMP          = st.clamp;

  // ========================================================================
  // Checks
  property p_rev_read;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (fall_c && st.st == ST_RD && st.bit_cnt == `DFC_ACK_SLOT && st.ptr == 8'h00)
    |=> (st.tx == REVISION);
  endproperty
  a_rev_read: assert property (p_rev_read)
    else $error("revision read wrong");

  property p_div_high;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (fall_c && st.st == ST_WR && st.bit_cnt == `DFC_BYTE_LAST && st.ptr == 8'h01)
    |=> (O_PLL_DIV[11:4] == $past(st.shift));
  endproperty
  a_div_high: assert property (p_div_high)
    else $error("divider high byte not stored");

  property p_low_zero;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (fall_c && st.st == ST_WR && st.bit_cnt == `DFC_BYTE_LAST && st.ptr == 8'h02)
    |=> (st.regs[2][3:0] == 4'h0) && (O_PLL_DIV[3:0] == $past(st.shift[7:4]));
  endproperty
  a_low_zero: assert property (p_low_zero)
    else $error("divider low nibble wrong");

  property p_addr_ack;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (fall_c && st.st == ST_ADDR && st.bit_cnt == `DFC_BYTE_LAST &&
     st.shift[7:1] == DEV_ADDR) |=> O_SDA_OE;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address not acknowledged");

  property p_aligned_line_sync_output_end;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (st.hs_cnt == 8'h01 && !lead) |=> (st.hs_cnt == 8'h00) &&
    (O_ALIGNED_LINE_SYNC_OUTPUT == $past(ctl[5]));
  endproperty
  a_aligned_line_sync_output_end: assert property (p_aligned_line_sync_output_end)
    else $error("line sync pulse too long");

  property p_clamp_place;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (trail && st.regs[5] == 8'h02) ##1 (!trail) [*2]
    |-> (!st.cl_on && !$past(st.cl_on)) ##1 st.cl_on;
  endproperty
  a_clamp_place: assert property (p_clamp_place)
    else $error("clamp start misplaced");

  property p_clamp_len;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (st.cl_on && st.cl_cnt == 8'h01 && !trail) |=> !st.cl_on;
  endproperty
  a_clamp_len: assert property (p_clamp_len)
    else $error("clamp held too long");

  property p_ext_clamp;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    cfg[7] |=> (O_CLAMP == ($past(I_EXT_CLAMP) ^ $past(cfg[6])));
  endproperty
  a_ext_clamp: assert property (p_ext_clamp)
    else $error("external clamp not followed");

  property p_vs_inv;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (!ctl[2] && !ctl[1] && !I_AUTO_FRAME_SYNC_SOURCE_FLAG)
    |=> (O_FRAME_SYNC_OUT == !$past(I_VSYNC_RAW));
  endproperty
  a_vs_inv: assert property (p_vs_inv)
    else $error("frame sync not inverted");

endmodule

// >>> inc/dfc_params.svh
// Offsets, field positions, reset values and masks of the front-end control registers.
// Assumes inclusion by the register bank and its bench only.
`ifndef DFC_PARAMS_SVH
`define DFC_PARAMS_SVH

// ==========================================================================
// Serial port
`define DFC_DEV_ADDR        7'h4C
`define DFC_BYTE_LAST       4'h7
`define DFC_ACK_SLOT        4'h8

// ==========================================================================
// Register offsets
`define DFC_REG_REVISION    8'h00
`define DFC_REG_DIV_HIGH    4'h1
`define DFC_REG_DIV_LOW     4'h2
`define DFC_REG_VCO_PUMP    4'h3
`define DFC_REG_PHASE       4'h4
`define DFC_REG_CLAMP_DLY   4'h5
`define DFC_REG_CLAMP_LEN   4'h6
`define DFC_REG_ALIGNED_LINE_SYNC_OUTPUT_WIDTH 4'h7
`define DFC_REG_RED_GAIN    4'h8
`define DFC_REG_GREEN_GAIN  4'h9
`define DFC_REG_BLUE_GAIN   4'hA
`define DFC_REG_RED_OFS     4'hB
`define DFC_REG_GREEN_OFS   4'hC
`define DFC_REG_BLUE_OFS    4'hD
`define DFC_REG_SYNC_CTL    4'hE
`define DFC_REG_CLAMP_CTL   4'hF
`define DFC_REG_STATUS      8'h14

// ==========================================================================
// Reset values
`define DFC_RST_DIV_HIGH    8'h69
`define DFC_RST_DIV_LOW     8'hD0
`define DFC_RST_VCO_PUMP    8'h48
`define DFC_RST_MID         8'h80
`define DFC_RST_ALIGNED_LINE_SYNC_OUTPUT_WIDTH 8'h20
`define DFC_RST_SYNC_CTL    8'h40
`define DFC_RST_CLAMP_CTL   8'h4E

// ==========================================================================
// Read masks of partial-width registers
`define DFC_MASK_NIBBLE     8'hF0
`define DFC_MASK_FIVE       8'hF8
`define DFC_MASK_SEVEN      8'hFE
`define DFC_MASK_FULL       8'hFF

// ==========================================================================
// Sync control and clamp control bits
`define DFC_SC_HPOL_OVR     7
`define DFC_SC_HPOL         6
`define DFC_SC_HOUT_POL     5
`define DFC_SC_HSRC_OVR     4
`define DFC_SC_HSRC         3
`define DFC_SC_VS_NOINV     2
`define DFC_SC_VSRC_OVR     1
`define DFC_SC_VSRC         0
`define DFC_CC_EXT_CLAMP    7
`define DFC_CC_CLAMP_POL    6

`endif

// >>> inc/dfc_pkg.sv
// Types of the front-end control register bank.
// Assumes dfc_params.svh sits in the include path.
package dfc_pkg;

  // ========================================================================
  // Serial slave states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WR,
    ST_RD
  } dfc_state_t;

  // ========================================================================
  // Whole state of the bank
  typedef struct packed {
    dfc_state_t       st;
    logic [3:0]       bit_cnt;
    logic [7:0]       shift;
    logic [7:0]       tx;
    logic [7:0]       ptr;
    logic             drive;
    logic             scl_q;
    logic             sda_q;
    logic [15:0][7:0] regs;
    logic             hs_prev;
    logic [7:0]       hs_cnt;
    logic             aligned_line_sync_output;
    logic             cl_wait;
    logic             cl_on;
    logic [7:0]       cl_cnt;
    logic             clamp;
    logic             vsout;
  } dfc_regs_t;

endpackage

// >>> verif/dfc_ctl_model.sv
// Behavioural two-wire controller that reads and writes the control bank.
// Assumes the bench resolves SDA with a pull-up and feeds the level to i_sda.
`timescale 1ns/1ps

module dfc_ctl_model (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // Quarter SCL period in system clocks; raise it to act as a slow controller
  int half = 4;

  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // ==========================================================================
  // Bus phases, every change lands on a falling clock edge
  task automatic hp();
    repeat (half) @(negedge i_clk);
  endtask

  // Data set while SCL low, sampled mid SCL high so device output settles
  task automatic bit_io(input logic b, output logic s);
    o_scl = 1'b0;
    hp();
    o_sda = b;
    hp();
    o_scl = 1'b1;
    hp();
    s = i_sda;
    hp();
  endtask

  task automatic start();
    o_scl = 1'b0;
    hp();
    o_sda = 1'b1;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda = 1'b0;
    hp();
  endtask

  task automatic stop();
    o_scl = 1'b0;
    hp();
    o_sda = 1'b0;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda = 1'b1;
    hp();
  endtask

  // Eight bits MSB first, then the device acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // Released line during data; last byte answered with NACK
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask
endmodule

// >>> verif/dfc_regs_tb.sv
// Self-checking bench of the control bank, driven through the two-wire port.
// Assumes dfc_params.svh in the include path and the controller model alongside.
`timescale 1ns/1ps
`include "dfc_params.svh"

module dfc_regs_tb;
  // Arbitrary value
  localparam logic [7:0] REV = 8'hA5;
  logic clk, rst, scl, m_sda, sda_wire, sda_out, sda_oe;
  logic hsync, sog, vs_raw, vs_sep, ext_cl, hs_det, sog_det, pol_det, a_line, a_frame;
  logic [11:0] pll_div;
  logic [1:0] vco;
  logic [2:0] pump;
  logic [4:0] phase;
  logic [7:0] rg, gg, bg;
  logic [6:0] ro, go, bo;
  logic lpol, lsog, alo, fso, clamp;
  int miscompares = 0;
  int checked = 0;
  logic [7:0] rst_tab [16] = '{REV, 8'h69, 8'hD0, 8'h48, 8'h80, 8'h80, 8'h80, 8'h20,
                              8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h40, 8'h4E};
  logic [7:0] sc_tab [9] = '{8'h00, 8'hC0, 8'h80, 8'h18, 8'h10, 8'h08, 8'h07, 8'h03, 8'h04};

  // Open-drain data line with pull-up
  assign sda_wire = m_sda & (sda_oe ? sda_out : 1'b1);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  dfc_ctl_model ctl_u (.i_clk(clk), .i_sda(sda_wire), .o_scl(scl), .o_sda(m_sda));

  dfc_regs #(.DEV_ADDR(`DFC_DEV_ADDR), .REVISION(REV)) dut_u (
    .I_CLK_SYS(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda_wire),
    .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .I_HSYNC(hsync), .I_SOG_SYNC(sog),
    .I_VSYNC_RAW(vs_raw), .I_VSYNC_SEP(vs_sep), .I_EXT_CLAMP(ext_cl),
    .I_HSYNC_DETECT(hs_det), .I_SOG_DETECT(sog_det), .I_HSYNC_POL_DET(pol_det),
    .I_AUTO_LINE_SYNC_SOURCE_FLAG(a_line), .I_AUTO_FRAME_SYNC_SOURCE_FLAG(a_frame),
    .O_PLL_DIV(pll_div), .O_VCO_RANGE(vco), .O_PUMP_CURRENT(pump),
    .O_SAMPLE_PHASE(phase), .O_RED_GAIN(rg), .O_GREEN_GAIN(gg), .O_BLUE_GAIN(bg),
    .O_RED_OFFSET(ro), .O_GREEN_OFFSET(go), .O_BLUE_OFFSET(bo),
    .O_LINE_SYNC_POL(lpol), .O_LINE_SYNC_SOG(lsog),
    .O_ALIGNED_LINE_SYNC_OUTPUT(alo), .O_FRAME_SYNC_OUT(fso), .O_CLAMP(clamp));

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] pat(input int i);
    pat = {i[3:0], ~i[3:0]};
  endfunction

  // Unused low bits of partial-width registers read as zero
  function automatic logic [7:0] rmask(input int a);
    case (a)
      2:          rmask = 8'hF0;
      3, 4:       rmask = 8'hF8;
      11, 12, 13, 15: rmask = 8'hFE;
      default:    rmask = 8'hFF;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k1, k2, k3;
    ctl_u.start();
    ctl_u.send_byte({`DFC_DEV_ADDR, 1'b0}, k1);
    ctl_u.send_byte(a, k2);
    ctl_u.send_byte(d, k3);
    ctl_u.stop();
    chk("write acks", 24'h7, {21'h0, k1, k2, k3});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic k1, k2, k3;
    logic [7:0] d;
    ctl_u.start();
    ctl_u.send_byte({`DFC_DEV_ADDR, 1'b0}, k1);
    ctl_u.send_byte(a, k2);
    ctl_u.start();
    ctl_u.send_byte({`DFC_DEV_ADDR, 1'b1}, k3);
    ctl_u.recv_byte(1'b1, d);
    ctl_u.stop();
    chk("read acks", 24'h7, {21'h0, k1, k2, k3});
    chk("register read", {16'h0, e}, {16'h0, d});
  endtask

  // One line sync pulse of three clocks; counts output activity and clamp
  task automatic hs_pulse(input logic act, output int n_hs, output int dly, output int n_cl);
    n_hs = 0;
    dly = 0;
    n_cl = 0;
    hsync = 1'b1;
    for (int c = 0; c < 300; c++) begin
      @(negedge clk);
      if (c == 2) hsync = 1'b0;
      if (alo === act) n_hs++;
      if (clamp === 1'b1 && n_cl == 0) dly = c;
      if (clamp === 1'b1) n_cl++;
    end
  endtask

  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Expected run is near 37k clocks
  initial begin
    #800_000;
    miscompares++;
    stop_test();
  end

  // ==========================================================================
  // Tests
  initial begin
    logic [7:0] sc;
    logic k, v;
    int a, d1, d2, c;
    {rst, hsync, sog, vs_raw, vs_sep, ext_cl} = 6'b100000;
    {hs_det, sog_det, pol_det, a_line, a_frame} = 5'b00000;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("pll div", 24'h69D, {12'h0, pll_div});
    chk("vco pump phase", {14'h0, 2'h1, 3'h1, 5'h10}, {14'h0, vco, pump, phase});
    chk("gains", 24'h808080, {rg, gg, bg});
    chk("offsets", {3'h0, 21'h102040}, {3'h0, ro, go, bo});
    for (int i = 0; i < 16; i++) rdc(i[7:0], rst_tab[i]);
    // Burst from pointer 0, divider high byte before low byte
    ctl_u.start();
    ctl_u.send_byte({`DFC_DEV_ADDR, 1'b0}, k);
    ctl_u.send_byte(8'h00, k);
    for (int i = 0; i < 17; i++) ctl_u.send_byte(pat(i), k);
    ctl_u.stop();
    chk("last burst ack", 24'h1, {23'h0, k});
    for (int i = 0; i < 17; i++) rdc(i[7:0], i == 0 ? REV : i == 16 ? 8'h00 : pat(i) & rmask(i));
    chk("pll div", {12'h0, pat(1), 4'(pat(2) >> 4)}, {12'h0, pll_div});
    chk("vco pump phase", {14'h0, 5'(pat(3) >> 3), 5'(pat(4) >> 3)},
        {14'h0, vco, pump, phase});
    chk("gains", {pat(8), pat(9), pat(10)}, {rg, gg, bg});
    chk("offsets", {3'h0, 7'(pat(11) >> 1), 7'(pat(12) >> 1), 7'(pat(13) >> 1)},
        {3'h0, ro, go, bo});
    ctl_u.half = 9;
    rdc(8'h01, pat(1));
    ctl_u.half = 4;
    {hs_det, a_line, pol_det, a_frame, sog_det} = 5'b11010;
    rdc(`DFC_REG_STATUS, 8'hC8);
    {hs_det, a_line, pol_det, a_frame, sog_det} = 5'b00101;
    rdc(`DFC_REG_STATUS, 8'h22);
    ctl_u.start();
    ctl_u.send_byte({`DFC_DEV_ADDR ^ 7'h01, 1'b0}, k);
    ctl_u.stop();
    chk("foreign address ack", 24'h0, {23'h0, k});
    // Sync selection over nine control patterns and eight input mixes
    for (int j = 0; j < 9; j++) begin
      sc = sc_tab[j];
      wr(8'h0E, sc);
      for (int m = 0; m < 8; m++) begin
        {pol_det, a_line, a_frame} = m[2:0];
        hs_det = m[0];
        sog_det = m[1];
        vs_raw = m[0] ^ m[2];
        vs_sep = ~vs_raw;
        repeat (2) @(negedge clk);
        chk("line polarity", {23'h0, sc[7] ? sc[6] : pol_det}, {23'h0, lpol});
        k = (sc[4] | (hs_det & sog_det)) ? sc[3] : a_line;
        chk("line source", {23'h0, k}, {23'h0, lsog});
        v = (sc[1] ? sc[0] : a_frame) ? vs_sep : vs_raw;
        chk("frame sync", {23'h0, sc[2] ? v : ~v}, {23'h0, fso});
      end
    end
    // Aligned line sync width and internal clamp timing
    wr(8'h07, 8'h05);
    wr(8'h05, 8'h02);
    wr(8'h06, 8'h04);
    wr(8'h0F, 8'h00);
    wr(8'h0E, 8'hD0);
    hs_pulse(1'b1, a, d1, c);
    chk("line sync width", 24'd5, a[23:0]);
    chk("clamp length", 24'd4, c[23:0]);
    wr(8'h07, 8'h01);
    wr(8'h05, 8'h07);
    wr(8'h0E, 8'hF0);
    hs_pulse(1'b0, a, d2, c);
    chk("line sync width", 24'd1, a[23:0]);
    chk("clamp delay step", 24'd5, d2[23:0] - d1[23:0]);
    // External clamp, both active levels
    for (int e = 0; e < 4; e++) begin
      wr(8'h0F, {1'b1, e[1], 6'h00});
      ext_cl = e[0];
      repeat (3) @(negedge clk);
      chk("external clamp", {23'h0, e[0] ^ e[1]}, {23'h0, clamp});
    end
    stop_test();
  end
endmodule
